// ---- lnkrst_cfg.svh ----
// lnkrst_cfg.svh: timing figures and reset values for the link reset block
// assumes: included by its bare name from every file that needs a figure
`ifndef LNKRST_CFG_SVH
`define LNKRST_CFG_SVH

// system clock period
`define LNKRST_SYS_PERIOD_NS 10.0
// shortest cold reset pulse the controller gives
`define LNKRST_RST_LOW_MIN_US 1.0
// least delay from cold reset release to first bit clock toggle
`define LNKRST_RST2CLK_NS 162.8
// nominal bit clock phase width and its limits
`define LNKRST_BCLK_PHASE_NS 40.7
`define LNKRST_BCLK_PHASE_MIN_NS 32.56
`define LNKRST_BCLK_PHASE_MAX_NS 48.84
// width of the delay and phase counters
`define LNKRST_CNT_W 5
// reset values of the link outputs
`define LNKRST_BCLK_RST 1'h0
`define LNKRST_DATA_RST 1'h0

`endif

// ---- lnkrst_pkg.sv ----
// lnkrst_pkg.sv: types of the link reset and test mode entry block
// assumes: nothing
package lnkrst_pkg;

    // operating mode latched at cold reset release
    typedef enum logic [1:0] {
        lnkrst_normal,
        lnkrst_tester_isolation,
        lnkrst_vendor_test
    } lnkrst_mode_type;

    // link start-up sequence
    typedef enum logic [1:0] {
        lnkrst_in_reset,
        lnkrst_clk_delay,
        lnkrst_running
    } lnkrst_state_type;

endpackage : lnkrst_pkg

// ---- lnkrst_clk_if.sv ----
// lnkrst_clk_if.sv: carrier between the top and its bit clock generator
// assumes: both ends on clk_sys_i
`timescale 1ns/10ps
`default_nettype none

interface lnkrst_clk_if;
    logic run;
    logic bclk;
    logic rise;
    logic fall;

    modport gen (input run, output bclk, output rise, output fall);
    modport user (output run, input bclk, input rise, input fall);
endinterface : lnkrst_clk_if

`default_nettype wire

// ---- lnkrst_bclk_gen.sv ----
// lnkrst_bclk_gen.sv: master bit clock generator, fixed phase count of the system clock
// assumes: run is a level on clk_sys_i; clock held low while run is low
`timescale 1ns/10ps
`default_nettype none
`include "lnkrst_cfg.svh"

module lnkrst_bclk_gen
    import lnkrst_pkg::*;
#(
    parameter int PHASE_CYC = int'($floor(`LNKRST_BCLK_PHASE_NS / `LNKRST_SYS_PERIOD_NS))
) (
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic rst_i,
    // carrier
    lnkrst_clk_if.gen clk_if
);

    localparam logic [`LNKRST_CNT_W-1:0] PHASE_LAST = (`LNKRST_CNT_W)'(PHASE_CYC - 1);

    logic [`LNKRST_CNT_W-1:0] phase_cnt;
    logic bclk;
    logic toggle;

    assign toggle = clk_if.run && (phase_cnt == PHASE_LAST);

    // ****************************************************************
    // phase counter: each phase lasts PHASE_CYC system cycles
    // ****************************************************************
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            phase_cnt <= '0;
        end else if (!clk_if.run || toggle) begin
            phase_cnt <= '0;
        end else begin
            phase_cnt <= phase_cnt + 1'h1;
        end
    end

    // ****************************************************************
    // clock level and edge strobes
    // ****************************************************************
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            bclk <= `LNKRST_BCLK_RST;
            clk_if.rise <= 1'h0;
            clk_if.fall <= 1'h0;
        end else begin
            bclk <= clk_if.run ? (bclk ^ toggle) : `LNKRST_BCLK_RST;
            clk_if.rise <= toggle && !bclk;
            clk_if.fall <= toggle && bclk;
        end
    end

    assign clk_if.bclk = bclk;

endmodule : lnkrst_bclk_gen

`default_nettype wire

// ---- lnkrst_top.sv ----
// lnkrst_top.sv: cold reset, bit clock start-up and test mode entry of the serial audio link
// assumes: all link pins are asynchronous to clk_sys_i; outer logic resolves the pin wires
//
// Function
// - master bit clock starts no sooner than 162.8 ns after reset release.
// - no warm reset; only cold reset reinitialises the link logic.
// - master bit clock near 12.288 MHz, phases 32.56 to 48.84 ns.
// - all inputs low at reset release give normal operation.
// - data high at release: tester isolation, both link outputs released.
// - isolation releases link outputs within 25.0 ns of reset release.
// - frame marker high, data low at release: vendor test, output levels unchanged.
// - test mode held until a cold reset with all inputs low.
// - slot select low makes the device master; high makes it slave.
// - data changes on rising edges; device samples on falling edges.
`timescale 1ns/10ps
`default_nettype none
`include "lnkrst_cfg.svh"

module lnkrst_top
    import lnkrst_pkg::*;
#(
    parameter int RST2CLK_CYC = int'($ceil(`LNKRST_RST2CLK_NS / `LNKRST_SYS_PERIOD_NS))
) (
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic rst_i,
    // link pins from the controller
    input wire logic cold_reset_n_i,
    input wire logic frame_marker_i,
    input wire logic host_to_device_data_i,
    input wire logic slot_select_pin_i,
    // bit clock pin, two-way
    input wire logic serial_bit_clock_i,
    output logic serial_bit_clock_o,
    output logic serial_bit_clock_oe_o,
    // device-to-host data pin
    output logic device_to_host_data_o,
    output logic device_to_host_data_oe_o,
    // state shown to the rest of the device
    output logic link_master_o,
    output logic link_running_o,
    output logic tester_isolation_o,
    output logic vendor_test_o,
    output logic frame_start_o,
    output logic data_bit_o,
    output logic data_bit_valid_o
);

    localparam int NPIN = 5;
    localparam logic [`LNKRST_CNT_W-1:0] DELAY_LAST = (`LNKRST_CNT_W)'(RST2CLK_CYC - 1);

    logic [NPIN-1:0] pin_meta;
    logic [NPIN-1:0] pin_sync;
    logic rstn_s;
    logic mark_s;
    logic data_s;
    logic sel_s;
    logic bclk_s;
    logic rstn_q;
    logic bclk_q;
    logic mark_q;
    logic release_evt;
    logic link_master;
    logic bit_rise;
    logic bit_fall;
    logic [`LNKRST_CNT_W-1:0] delay_cnt;
    lnkrst_mode_type mode;
    lnkrst_state_type state;
    lnkrst_clk_if clk_if ();

    // ****************************************************************
    // pin synchronisers
    // ****************************************************************
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            pin_meta <= '0;
            pin_sync <= '0;
        end else begin
            pin_meta <= {serial_bit_clock_i, slot_select_pin_i, host_to_device_data_i,
                         frame_marker_i, cold_reset_n_i};
            pin_sync <= pin_meta;
        end
    end

    assign {bclk_s, sel_s, data_s, mark_s, rstn_s} = pin_sync;

    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            rstn_q <= 1'h0;
            bclk_q <= 1'h0;
            mark_q <= 1'h0;
        end else begin
            rstn_q <= rstn_s;
            bclk_q <= bclk_s;
            // marker level as seen at the last falling bit clock edge
            if (bit_fall) begin
                mark_q <= mark_s;
            end
        end
    end

    assign release_evt = rstn_s && !rstn_q;

    // ****************************************************************
    // mode capture at cold reset release
    // ****************************************************************
    // the cold reset pin is the only reinitialisation; frame marker pulses
    // with the clock stopped are ordinary frame marker activity
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            mode <= lnkrst_normal;
            link_master <= 1'h0;
        end else if (release_evt) begin
            link_master <= !sel_s;
            if (data_s) begin
                mode <= lnkrst_tester_isolation;
            end else if (mark_s) begin
                mode <= lnkrst_vendor_test;
            end else begin
                mode <= lnkrst_normal;
            end
        end
    end

    // ****************************************************************
    // start-up sequence
    // ****************************************************************
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            state <= lnkrst_in_reset;
            delay_cnt <= '0;
        end else if (!rstn_s) begin
            state <= lnkrst_in_reset;
            delay_cnt <= '0;
        end else begin
            unique case (state)
                lnkrst_in_reset: begin
                    state <= lnkrst_clk_delay;
                end
                lnkrst_clk_delay: begin
                    delay_cnt <= delay_cnt + 1'h1;
                    if (delay_cnt == DELAY_LAST) begin
                        state <= lnkrst_running;
                    end
                end
                lnkrst_running: begin
                    state <= lnkrst_running;
                end
            endcase
        end
    end

    // ****************************************************************
    // bit clock source
    // ****************************************************************
    assign clk_if.run = (state == lnkrst_running) && link_master;

    lnkrst_bclk_gen u_bclk_gen (
        .clk_sys_i(clk_sys_i),
        .rst_i(rst_i),
        .clk_if(clk_if)
    );

    assign bit_rise = link_master ? clk_if.rise : (bclk_s && !bclk_q);
    assign bit_fall = link_master ? clk_if.fall : (!bclk_s && bclk_q);

    // ****************************************************************
    // serial sampling on falling bit clock edges
    // ****************************************************************
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            data_bit_o <= 1'h0;
            data_bit_valid_o <= 1'h0;
            frame_start_o <= 1'h0;
        end else begin
            data_bit_valid_o <= bit_fall && (state == lnkrst_running);
            if (bit_fall) begin
                data_bit_o <= data_s;
            end
            frame_start_o <= bit_fall && mark_s && !mark_q && (state == lnkrst_running);
        end
    end

    // ****************************************************************
    // link output pins
    // ****************************************************************
    // while cold reset is held the data line is watched continuously, so an
    // isolation request has already released the pins when reset rises
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            serial_bit_clock_o <= `LNKRST_BCLK_RST;
            serial_bit_clock_oe_o <= 1'h0;
            device_to_host_data_o <= `LNKRST_DATA_RST;
            device_to_host_data_oe_o <= 1'h0;
        end else begin
            serial_bit_clock_o <= clk_if.bclk;
            device_to_host_data_o <= `LNKRST_DATA_RST;
            if (!rstn_s) begin
                serial_bit_clock_oe_o <= !sel_s && !data_s;
                device_to_host_data_oe_o <= !data_s;
            end else if (release_evt) begin
                serial_bit_clock_oe_o <= !sel_s && !data_s;
                device_to_host_data_oe_o <= !data_s;
            end else begin
                serial_bit_clock_oe_o <= link_master && (mode != lnkrst_tester_isolation);
                device_to_host_data_oe_o <= mode != lnkrst_tester_isolation;
            end
        end
    end

    // ****************************************************************
    // status
    // ****************************************************************
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            link_master_o <= 1'h0;
            link_running_o <= 1'h0;
            tester_isolation_o <= 1'h0;
            vendor_test_o <= 1'h0;
        end else begin
            link_master_o <= link_master;
            link_running_o <= state == lnkrst_running;
            tester_isolation_o <= mode == lnkrst_tester_isolation;
            vendor_test_o <= mode == lnkrst_vendor_test;
        end
    end

endmodule : lnkrst_top

`default_nettype wire

// ---- lnkrst_checker.sv ----
// lnkrst_checker.sv: port assertions of the link reset block
// assumes: bound to lnkrst_top, all ports on clk_sys_i
`timescale 1ns/10ps
`default_nettype none

module lnkrst_checker #(
    parameter int RST2CLK_CYC = 17
) (
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic rst_i,
    // link inputs
    input wire logic cold_reset_n_i,
    input wire logic frame_marker_i,
    input wire logic host_to_device_data_i,
    input wire logic slot_select_pin_i,
    // link outputs and state
    input wire logic serial_bit_clock_o,
    input wire logic serial_bit_clock_oe_o,
    input wire logic device_to_host_data_oe_o,
    input wire logic link_master_o,
    input wire logic tester_isolation_o,
    input wire logic vendor_test_o
);
    // ****************
    // release tracking
    // ****************
    logic [5:0] rel_cnt;
    logic dat_r, fm_r, sel_r;
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (rst_i);
    // edges since the cold reset pin rose, saturating
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            rel_cnt <= 6'h00;
        end else if (!cold_reset_n_i) begin
            rel_cnt <= 6'h00;
        end else if (rel_cnt != 6'h3F) begin
            rel_cnt <= rel_cnt + 6'h01;
        end
    end
    always_ff @(posedge clk_sys_i) begin
        if (cold_reset_n_i && rel_cnt == 6'h00) begin
            dat_r <= host_to_device_data_i;
            fm_r <= frame_marker_i;
            sel_r <= slot_select_pin_i;
        end
    end
    a_mode_latch: assert property (
        rel_cnt == 6'h08 |-> tester_isolation_o == dat_r
            && vendor_test_o == (fm_r && !dat_r) && link_master_o == !sel_r)
        else $error("mode differs from pin levels at release");
    a_mode_held: assert property (
        rel_cnt >= 6'h09 |-> $stable(tester_isolation_o) && $stable(vendor_test_o)
            && $stable(link_master_o))
        else $error("mode changed after release");
    a_modes_exclusive: assert property (
        !(tester_isolation_o && vendor_test_o))
        else $error("both test modes at once");
    a_iso_pins_off: assert property (
        rel_cnt >= 6'h08 && tester_isolation_o |->
            !serial_bit_clock_oe_o && !device_to_host_data_oe_o)
        else $error("isolation left a link output driven");
    a_iso_fast_off: assert property (
        (host_to_device_data_i && !cold_reset_n_i)[*5] ##1 cold_reset_n_i |->
            (!serial_bit_clock_oe_o && !device_to_host_data_oe_o)[*3])
        else $error("outputs not released soon after release");
    a_pins_normal: assert property (
        rel_cnt >= 6'h08 && !tester_isolation_o |->
            serial_bit_clock_oe_o == link_master_o && device_to_host_data_oe_o)
        else $error("output enables wrong outside isolation");
    a_clk_start_late: assert property (disable iff (rst_i || !cold_reset_n_i)
        $rose(serial_bit_clock_o) |-> int'(rel_cnt) >= RST2CLK_CYC)
        else $error("bit clock started too early");
    a_phase_high: assert property (disable iff (rst_i || !cold_reset_n_i)
        $rose(serial_bit_clock_o) |-> serial_bit_clock_o[*4] ##1 !serial_bit_clock_o)
        else $error("bit clock high phase not 40 ns");
    a_phase_low: assert property (disable iff (rst_i || !cold_reset_n_i)
        $fell(serial_bit_clock_o) |-> !serial_bit_clock_o[*4] ##1 serial_bit_clock_o)
        else $error("bit clock low phase not 40 ns");
endmodule : lnkrst_checker

bind lnkrst_top lnkrst_checker #(.RST2CLK_CYC(RST2CLK_CYC)) u_chk (.*);

`default_nettype wire

// ---- lnkrst_ctrl_model.sv ----
// lnkrst_ctrl_model.sv: behavioural link controller
// assumes: bench resolves the bit clock wire; own clock is used in slave mode
`timescale 1ns/10ps
`default_nettype none

module lnkrst_ctrl_model (
    // clocks
    input wire logic clk_sys_i,
    input wire logic dev_bclk_i,
    input wire logic dev_master_i,
    // link pins towards the device
    output logic cold_reset_n_o,
    output logic frame_marker_o,
    output logic host_to_device_data_o,
    output logic serial_bit_clock_o
);
    // ****************
    // frames
    // ****************
    logic run = 1'b0;
    logic own_clk = 1'b0;
    logic [7:0] bit_cnt = 8'h00;
    wire logic link_clk = dev_master_i ? dev_bclk_i : own_clk;
    assign serial_bit_clock_o = own_clk;
    initial begin
        cold_reset_n_o = 1'b0;
        frame_marker_o = 1'b0;
        host_to_device_data_o = 1'b0;
        #3;
        // 80 ns link clock, still while no frames run
        forever #40 own_clk = run & !own_clk;
    end
    always @(posedge link_clk) begin
        if (run) begin
            bit_cnt <= bit_cnt + 8'h01;
            frame_marker_o <= (bit_cnt < 8'h10);
            host_to_device_data_o <= bit_cnt[0] ^ bit_cnt[4];
        end
    end
    task automatic frames(input logic on);
        bit_cnt = 8'h00;
        run = on;
    endtask : frames
    task automatic cold_reset(input logic dat, input logic fm);
        run = 1'b0;
        @(posedge clk_sys_i);
        cold_reset_n_o <= 1'b0;
        frame_marker_o <= fm;
        host_to_device_data_o <= dat;
        repeat (100) @(posedge clk_sys_i);
        cold_reset_n_o <= 1'b1;
        repeat (3) @(posedge clk_sys_i);
        frame_marker_o <= 1'b0;
        host_to_device_data_o <= 1'b0;
    endtask : cold_reset
    task automatic warm_pulse();
        @(posedge clk_sys_i);
        frame_marker_o <= 1'b1;
        host_to_device_data_o <= 1'b1;
        repeat (130) @(posedge clk_sys_i);
        frame_marker_o <= 1'b0;
        host_to_device_data_o <= 1'b0;
    endtask : warm_pulse
endmodule : lnkrst_ctrl_model

`default_nettype wire

// ---- lnkrst_top_test.sv ----
// lnkrst_top_test.sv: self-checking bench of the link reset block
// assumes: controller model on the far side, checker bound to the top
`timescale 1ns/10ps
`default_nettype none

module lnkrst_top_test;
    import lnkrst_pkg::*;
    // ****************
    // bench
    // ****************
    logic clk_sys_i, rst_i, slot_select_pin_i, ctrl_bclk;
    logic cold_reset_n_i, frame_marker_i, host_to_device_data_i, serial_bit_clock_i;
    logic serial_bit_clock_o, serial_bit_clock_oe_o, device_to_host_data_o;
    logic device_to_host_data_oe_o, link_master_o, link_running_o;
    logic tester_isolation_o, vendor_test_o, frame_start_o, data_bit_o, data_bit_valid_o;
    logic bclk_d;
    int err_count = 0;
    int check_count = 0;
    int rises = 0;
    int starts = 0;
    int valids = 0;
    int nbits = 0;
    logic [31:0] frame_bits = '0;
    logic [31:0] frame_word = '0;
    assign serial_bit_clock_i = serial_bit_clock_oe_o ? serial_bit_clock_o : ctrl_bclk;
    lnkrst_top dut (.*);
    lnkrst_ctrl_model u_ctrl (
        .clk_sys_i(clk_sys_i),
        .dev_bclk_i(serial_bit_clock_o),
        .dev_master_i(link_master_o),
        .cold_reset_n_o(cold_reset_n_i),
        .frame_marker_o(frame_marker_i),
        .host_to_device_data_o(host_to_device_data_i),
        .serial_bit_clock_o(ctrl_bclk)
    );
    initial begin
        clk_sys_i = 1'b0;
        forever #5 clk_sys_i = !clk_sys_i;
    end
    // rises count only while the device drives the bit clock pin
    always @(posedge clk_sys_i) begin
        bclk_d <= serial_bit_clock_o && serial_bit_clock_oe_o;
        if (serial_bit_clock_o && serial_bit_clock_oe_o && !bclk_d) rises++;
        if (frame_start_o) starts++;
        if (data_bit_valid_o) begin
            valids++;
            frame_bits = {frame_bits[30:0], data_bit_o};
            if (frame_start_o) begin
                nbits = 1;
            end else if (nbits != 0 && nbits < 33) begin
                nbits++;
            end
            if (nbits == 32) frame_word = frame_bits;
        end
    end
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            err_count++;
            $display("unexpected %s: expected %0h, seen %0h", what, exp, seen);
        end
    endtask : check
    task automatic count_for(input int n);
        @(negedge clk_sys_i);
        rises = 0;
        starts = 0;
        valids = 0;
        frame_word = '0;
        repeat (n) @(negedge clk_sys_i);
    endtask : count_for
    task automatic reset_to(input logic dat, input logic fm);
        u_ctrl.cold_reset(dat, fm);
        repeat (40) @(posedge clk_sys_i);
    endtask : reset_to
    task automatic expect_modes(input logic m, input logic t, input logic v);
        check("link_master_o", link_master_o, m);
        check("tester_isolation_o", tester_isolation_o, t);
        check("vendor_test_o", vendor_test_o, v);
        check("bclk oe", serial_bit_clock_oe_o, m & !t);
        check("data oe", device_to_host_data_oe_o, !t);
        check("device_to_host_data_o", device_to_host_data_o, 1'b0);
        check("link_running_o", link_running_o, 1'b1);
    endtask : expect_modes
    task automatic test_normal();
        reset_to(1'b0, 1'b0);
        expect_modes(1'b1, 1'b0, 1'b0);
        count_for(400);
        check("bit clock rises", rises, 32'h32);
        check("valid bits", valids, 32'h32);
        u_ctrl.frames(1'b1);
        count_for(4000);
        check("frame starts", starts, 32'h2);
        check("frame bits", frame_word, 32'h5555AAAA);
        u_ctrl.frames(1'b0);
        $display("test normal done");
    endtask : test_normal
    task automatic test_isolation();
        reset_to(1'b1, 1'b0);
        expect_modes(1'b1, 1'b1, 1'b0);
        u_ctrl.warm_pulse();
        count_for(400);
        check("bit clock rises", rises, 32'h0);
        expect_modes(1'b1, 1'b1, 1'b0);
        $display("test isolation done");
    endtask : test_isolation
    task automatic test_vendor();
        reset_to(1'b0, 1'b1);
        expect_modes(1'b1, 1'b0, 1'b1);
        count_for(400);
        check("bit clock rises", rises, 32'h32);
        $display("test vendor done");
    endtask : test_vendor
    task automatic test_both_high();
        reset_to(1'b1, 1'b1);
        expect_modes(1'b1, 1'b1, 1'b0);
        $display("test both high done");
    endtask : test_both_high
    task automatic test_return();
        reset_to(1'b0, 1'b0);
        expect_modes(1'b1, 1'b0, 1'b0);
        $display("test return done");
    endtask : test_return
    task automatic test_slave();
        @(posedge clk_sys_i);
        slot_select_pin_i <= 1'b1;
        reset_to(1'b0, 1'b0);
        expect_modes(1'b0, 1'b0, 1'b0);
        u_ctrl.frames(1'b1);
        count_for(4000);
        check("bit clock rises", rises, 32'h0);
        check("frame starts", starts, 32'h2);
        check("frame bits", frame_word, 32'h5555AAAA);
        u_ctrl.frames(1'b0);
        $display("test slave done");
    endtask : test_slave
    task automatic print_verdict();
        $display("checks %0d, mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : print_verdict
    initial begin
        rst_i = 1'b1;
        slot_select_pin_i = 1'b0;
        repeat (10) @(posedge clk_sys_i);
        rst_i <= 1'b0;
        test_normal();
        test_isolation();
        test_vendor();
        test_both_high();
        test_return();
        test_slave();
        print_verdict();
    end
    initial begin
        repeat (30000) @(posedge clk_sys_i);
        err_count++;
        print_verdict();
    end
endmodule : lnkrst_top_test

`default_nettype wire
